// [rtl/lsd_clk_switch.sv]
`timescale 1ns/100ps
module lsd_clk_switch #(
   parameter int FRAME_DIV = lsd_pkg::LSD_FRAME_DIV
) (
   input  wire logic clk_in,          // Internal oscillator.
   input  wire logic ext_clk_in,      // External clock from the clock pin.
   input  wire logic rst_n_in,        // Asynchronous reset, active low.
   input  wire logic sel_ext_in,      // Source select, clk_in domain.
   output logic      disp_clk_out,    // Glitch-free display clock.
   output logic      ext_active_out,  // External source in use, clk_in domain.
   output logic      frame_phase_out  // Frame clock, FRAME_DIV display clocks.
);

   localparam int FW = $clog2(FRAME_DIV);

   logic          ext_en_meta_q;
   logic          ext_en_sync_q;
   logic          int_arm_q;
   logic          int_en_q;
   logic          sel_meta_q;
   logic          sel_sync_q;
   logic          int_meta_q;
   logic          int_sync_q;
   logic          ext_arm_q;
   logic          ext_en_q;
   logic [FW-1:0] frame_cnt_q;
   logic          frame_q;
   wire           frame_wrap;

   // Internal side arms only once the external gate is seen closed. [RULE20]
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_en_meta_q <= 1'h0;
         ext_en_sync_q <= 1'h0;
         int_arm_q     <= 1'h1;
      end else begin
         ext_en_meta_q <= ext_en_q;
         ext_en_sync_q <= ext_en_meta_q;
         int_arm_q     <= ~sel_ext_in & ~ext_en_sync_q; // [RULE5] [RULE20]
      end
   end

   // Gate changes on the falling edge so a high phase is never cut short.
   always_ff @(negedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) int_en_q <= 1'h1;
      else           int_en_q <= int_arm_q;
   end

   // External side: select and internal gate both cross on two flops.
   always_ff @(posedge ext_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_meta_q <= 1'h0;
         sel_sync_q <= 1'h0;
         int_meta_q <= 1'h1;
         int_sync_q <= 1'h1;
         ext_arm_q  <= 1'h0;
      end else begin
         sel_meta_q <= sel_ext_in;
         sel_sync_q <= sel_meta_q;
         int_meta_q <= int_en_q;
         int_sync_q <= int_meta_q;
         ext_arm_q  <= sel_sync_q & ~int_sync_q; // [RULE20]
      end
   end

   always_ff @(negedge ext_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) ext_en_q <= 1'h0;
      else           ext_en_q <= ext_arm_q;
   end

   // At most one gate is open, so the OR never merges two pulses.
   assign disp_clk_out   = (clk_in & int_en_q) | (ext_clk_in & ext_en_q); // [RULE20]
   assign ext_active_out = ext_en_sync_q;

   // Frame timing divides whichever clock is selected, so it scales with it.
   assign frame_wrap = (frame_cnt_q == FW'(FRAME_DIV - 1));

   always_ff @(posedge disp_clk_out or negedge rst_n_in) begin
      if (!rst_n_in) frame_cnt_q <= '0;
      else           frame_cnt_q <= frame_wrap ? '0 : frame_cnt_q + FW'(1); // [RULE9]
   end

   always_ff @(posedge disp_clk_out or negedge rst_n_in) begin
      if (!rst_n_in) frame_q <= 1'h0;
      else           frame_q <= (frame_cnt_q < FW'(FRAME_DIV / 2)); // [RULE9]
   end

   assign frame_phase_out = frame_q;

endmodule

// [rtl/lsd_setup_decoder.sv]
`timescale 1ns/100ps
// Behaviour
// RULE1: Reload calibration on command, boot and initialize.
// RULE2: Host avoids power-down during calibration reload.
// RULE3: Upper bits 110011 select oscillator control.
// RULE4: Clock pin drive bit: 0 three-state, 1 drives.
// RULE5: Source bit 1 selects the external clock input.
// RULE6: Clock pin stays three-state after power-on.
// RULE7: Pump enabled keeps internal oscillator running.
// RULE8: Output clock duty cycle follows frame setting; here the high time comes from clko_high_in instead.
// RULE9: Frame timing scales with the selected clock.
// RULE10: Host keeps external clock running once selected.
// RULE11: Upper bits 110000 control the charge pump.
// RULE12: Pump multiplier bit: 0 doubles, 1 triples.
// RULE13: Upper bits 110010; bit 1 thermal compensation.
// RULE14: Bit 0 switches temperature measurement, default on.
// RULE15: Four 3-bit slope coefficients, default zero.
// RULE16: Chip reset only after both initialize bytes.
// RULE17: Setup commands arrive with register select low.
// RULE18: Settings hold until rewritten or reset.
// RULE19: Unknown command bytes change no stored setting.
// RULE20: Clock source switching produces no glitches.
module lsd_setup_decoder #(
   parameter int CLKO_DIV        = lsd_pkg::LSD_CLKO_DIV,
   parameter int FRAME_DIV       = lsd_pkg::LSD_FRAME_DIV,
   parameter int OTP_LOAD_CYCLES = lsd_pkg::LSD_OTP_LOAD_CYC,
   parameter int CAL_W           = lsd_pkg::LSD_CAL_W
) (
   input  wire logic                      clk_in,              // Internal oscillator, 100 MHz.
   input  wire logic                      rst_n_in,            // Reset pin, active low.
   input  wire logic                      ext_clk_in,          // Clock pin input side.
   input  wire logic                      cmd_valid_in,        // One-cycle byte strobe.
   input  wire lsd_pkg::lsd_cmd_t         cmd_in,              // Byte and register select.
   input  wire logic [CAL_W-1:0]          otp_cal_in,          // Calibration cell contents.
   input  wire logic [$clog2(CLKO_DIV):0] clko_high_in,        // High cycles of output clock.
   output lsd_pkg::lsd_cfg_t              cfg_out,             // Stored settings.
   output logic                           clk_pin_out,         // Clock pin drive value.
   output logic                           clk_pin_oe_out,      // Clock pin output enable.
   output logic                           osc_run_out,         // Internal oscillator request.
   output logic                           pump_clk_en_out,     // Pump runs from oscillator.
   output logic                           otp_busy_out,        // Calibration reload running.
   output logic [CAL_W-1:0]               cal_out,             // Loaded calibration values.
   output logic                           chip_init_out,       // Chip-wide reset pulse.
   output logic                           disp_clk_out,        // Display timing clock.
   output logic                           ext_active_out,      // External source in use.
   output logic                           frame_phase_out      // Frame clock.
);

   localparam int CW  = $clog2(CLKO_DIV) + 1;
   localparam int OW  = $clog2(OTP_LOAD_CYCLES + 1);

   // True when the masked bits of a byte equal the masked opcode.
   function automatic logic op_match(input logic [7:0] b, input logic [7:0] op,
                                     input logic [7:0] mask);
      op_match = ((b & mask) == (op & mask));
   endfunction

   typedef enum logic [1:0] {
      LSD_INIT_IDLE  = 2'h1,
      LSD_INIT_ARMED = 2'h2
   } lsd_init_state_t;

   lsd_pkg::lsd_cfg_t cfg_q;
   lsd_pkg::lsd_cfg_t cfg_d;
   lsd_init_state_t   init_q;
   lsd_init_state_t   init_d;
   logic              boot_q;
   logic [OW-1:0]     otp_cnt_q;
   logic [OW-1:0]     otp_cnt_d;
   logic [CAL_W-1:0]  cal_q;
   logic              init_pulse_q;
   logic [CW-1:0]     clko_cnt_q;
   logic              clko_q;
   logic              pin_q;
   logic              pin_oe_q;

   wire [7:0] b = cmd_in.data;
   wire       hi_bit = b[lsd_pkg::LSD_POS_HI_FLAG];
   wire       lo_bit = b[lsd_pkg::LSD_POS_LO_FLAG];
   wire [lsd_pkg::LSD_SLOPE_W-1:0] slope_val =
      b[lsd_pkg::LSD_SLOPE_LSB +: lsd_pkg::LSD_SLOPE_W];

   // Bytes flagged as display data are never treated as commands.
   wire is_cmd = cmd_valid_in & ~cmd_in.register_select_flag; // [RULE17]

   // Opcode decode; anything not listed below falls through untouched.
   wire hit_otp   = is_cmd & op_match(b, lsd_pkg::LSD_OP_OTP_RELOAD,
                                      lsd_pkg::LSD_MASK_FULL); // [RULE1]
   wire hit_osc   = is_cmd & op_match(b, lsd_pkg::LSD_OP_OSC_CTRL,
                                      lsd_pkg::LSD_MASK_UPPER6); // [RULE3]
   wire hit_pump  = is_cmd & op_match(b, lsd_pkg::LSD_OP_PUMP_CTRL,
                                      lsd_pkg::LSD_MASK_UPPER6); // [RULE11]
   wire hit_temp  = is_cmd & op_match(b, lsd_pkg::LSD_OP_TEMP_CTRL,
                                      lsd_pkg::LSD_MASK_UPPER6); // [RULE13]
   wire hit_slp_a = is_cmd & op_match(b, lsd_pkg::LSD_OP_SLOPE_A,
                                      lsd_pkg::LSD_MASK_UPPER5); // [RULE15]
   wire hit_slp_b = is_cmd & op_match(b, lsd_pkg::LSD_OP_SLOPE_B,
                                      lsd_pkg::LSD_MASK_UPPER5); // [RULE15]
   wire hit_slp_c = is_cmd & op_match(b, lsd_pkg::LSD_OP_SLOPE_C,
                                      lsd_pkg::LSD_MASK_UPPER5); // [RULE15]
   wire hit_slp_d = is_cmd & op_match(b, lsd_pkg::LSD_OP_SLOPE_D,
                                      lsd_pkg::LSD_MASK_UPPER5); // [RULE15]
   wire hit_init1 = is_cmd & op_match(b, lsd_pkg::LSD_OP_INIT_FIRST,
                                      lsd_pkg::LSD_MASK_FULL);
   wire hit_init2 = is_cmd & op_match(b, lsd_pkg::LSD_OP_INIT_SECOND,
                                      lsd_pkg::LSD_MASK_FULL);

   // The reset fires only when the second byte directly follows the first.
   wire init_fire = hit_init2 & (init_q == LSD_INIT_ARMED); // [RULE16]

   // Any reload request restarts the timer; a running reload is not merged.
   wire otp_start = boot_q | hit_otp | init_fire; // [RULE1]
   wire otp_last  = (otp_cnt_q == OW'(1));

   // Initialize sequence tracker: any other valid byte breaks the pair.
   always_comb begin
      init_d = init_q;
      case (init_q)
         LSD_INIT_IDLE: begin
            if (hit_init1) init_d = LSD_INIT_ARMED; // [RULE16]
         end
         LSD_INIT_ARMED: begin
            if (cmd_valid_in && !hit_init1) init_d = LSD_INIT_IDLE; // [RULE16]
         end
         default: init_d = LSD_INIT_IDLE;
      endcase
   end

   // Next settings: only matching commands write, defaults on initialize.
   always_comb begin
      cfg_d = cfg_q; // [RULE18] [RULE19]
      if (init_fire) begin
         cfg_d = lsd_pkg::LSD_CFG_DEFAULT; // [RULE16]
      end else begin
         if (hit_osc) begin
            cfg_d.clock_pin_drive     = hi_bit; // [RULE4]
            cfg_d.clock_source_select = lo_bit; // [RULE5]
         end
         if (hit_pump) begin
            cfg_d.pump_enable            = hi_bit; // [RULE11]
            cfg_d.pump_multiplier_select = lo_bit; // [RULE12]
         end
         if (hit_temp) begin
            cfg_d.thermal_comp_enable  = hi_bit; // [RULE13]
            cfg_d.thermal_sense_enable = lo_bit; // [RULE14]
         end
         if (hit_slp_a) cfg_d.slope_region_a = slope_val; // [RULE15]
         if (hit_slp_b) cfg_d.slope_region_b = slope_val; // [RULE15]
         if (hit_slp_c) cfg_d.slope_region_c = slope_val; // [RULE15]
         if (hit_slp_d) cfg_d.slope_region_d = slope_val; // [RULE15]
      end
   end

   // Reload timer: counts down from the load time while the cells are read.
   always_comb begin
      otp_cnt_d = otp_cnt_q;
      if (otp_start)               otp_cnt_d = OW'(OTP_LOAD_CYCLES); // [RULE1]
      else if (otp_cnt_q != '0)    otp_cnt_d = otp_cnt_q - OW'(1);
   end

   // Settings and initialize tracker.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_q  <= lsd_pkg::LSD_CFG_DEFAULT; // [RULE6] [RULE18]
         init_q <= LSD_INIT_IDLE;
      end else begin
         cfg_q  <= cfg_d;
         init_q <= init_d;
      end
   end

   // Boot flag starts a reload on the first edge after reset release.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         boot_q       <= 1'h1;
         otp_cnt_q    <= '0;
         init_pulse_q <= 1'h0;
      end else begin
         boot_q       <= 1'h0; // [RULE1]
         otp_cnt_q    <= otp_cnt_d;
         init_pulse_q <= init_fire;
      end
   end

   // Calibration values are taken at the end of the reload window.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)     cal_q <= '0;
      else if (otp_last && !otp_start) cal_q <= otp_cal_in; // [RULE1]
   end

   // Output clock divider; high time comes from clko_high_in, so the
   // duty cycle is generally not balanced.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) clko_cnt_q <= '0;
      else if (clko_cnt_q == CW'(CLKO_DIV - 1)) clko_cnt_q <= '0;
      else clko_cnt_q <= clko_cnt_q + CW'(1);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) clko_q <= 1'h0;
      else           clko_q <= (clko_cnt_q < clko_high_in); // [RULE8]
   end

   // The pin drives only with drive set and the internal source chosen;
   // with the external source it must stay an input.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_oe_q <= 1'h0; // [RULE6]
         pin_q    <= 1'h0;
      end else begin
         pin_oe_q <= cfg_q.clock_pin_drive & ~cfg_q.clock_source_select; // [RULE4] [RULE5]
         pin_q    <= clko_q & cfg_q.clock_pin_drive & ~cfg_q.clock_source_select; // [RULE4]
      end
   end

   // Source switching and frame timing; the external side relies on the
   // host keeping its clock alive while selected. [RULE10]
   lsd_clk_switch #(
      .FRAME_DIV (FRAME_DIV)
   ) u_clk_switch (
      .clk_in          (clk_in),
      .ext_clk_in      (ext_clk_in),
      .rst_n_in        (rst_n_in),
      .sel_ext_in      (cfg_q.clock_source_select), // [RULE5]
      .disp_clk_out    (disp_clk_out),
      .ext_active_out  (ext_active_out),
      .frame_phase_out (frame_phase_out)
   );

   // Oscillator runs for the internal source or whenever the pump is on.
   assign osc_run_out     = ~ext_active_out | cfg_q.pump_enable; // [RULE7]
   assign pump_clk_en_out = cfg_q.pump_enable; // [RULE7]

   // Reload status is visible so the host can hold off power-down. [RULE2]
   assign otp_busy_out   = (otp_cnt_q != '0);
   assign cal_out        = cal_q;
   assign chip_init_out  = init_pulse_q;
   assign cfg_out        = cfg_q;
   assign clk_pin_out    = pin_q;
   assign clk_pin_oe_out = pin_oe_q;

endmodule

// [shared/lsd_pkg.sv]
package lsd_pkg;

   // Command opcodes and the masks that pick out their fixed bits.
   localparam logic [7:0] LSD_OP_OTP_RELOAD  = 8'hD0;
   localparam logic [7:0] LSD_OP_INIT_FIRST  = 8'h3A;
   localparam logic [7:0] LSD_OP_INIT_SECOND = 8'h04;
   localparam logic [7:0] LSD_OP_OSC_CTRL    = 8'hCC;
   localparam logic [7:0] LSD_OP_PUMP_CTRL   = 8'hC0;
   localparam logic [7:0] LSD_OP_TEMP_CTRL   = 8'hC8;
   localparam logic [7:0] LSD_OP_SLOPE_A     = 8'h18;
   localparam logic [7:0] LSD_OP_SLOPE_B     = 8'h20;
   localparam logic [7:0] LSD_OP_SLOPE_C     = 8'h28;
   localparam logic [7:0] LSD_OP_SLOPE_D     = 8'h30;
   localparam logic [7:0] LSD_MASK_FULL      = 8'hFF;
   localparam logic [7:0] LSD_MASK_UPPER6    = 8'hFC;
   localparam logic [7:0] LSD_MASK_UPPER5    = 8'hF8;

   // Field positions inside the command byte.
   localparam int LSD_POS_HI_FLAG = 1;
   localparam int LSD_POS_LO_FLAG = 0;
   localparam int LSD_SLOPE_W     = 3;
   localparam int LSD_SLOPE_LSB   = 0;
   localparam int LSD_REGIONS     = 4;

   // Reset values of the stored settings.
   localparam logic                   LSD_RST_CLOCK_PIN_DRIVE     = 1'h0;
   localparam logic                   LSD_RST_CLOCK_SOURCE_SELECT = 1'h0;
   localparam logic                   LSD_RST_PUMP_ENABLE         = 1'h0;
   localparam logic                   LSD_RST_PUMP_MULT_SELECT    = 1'h0;
   localparam logic                   LSD_RST_THERMAL_COMP_ENABLE = 1'h1;
   localparam logic                   LSD_RST_THERMAL_SENSE_EN    = 1'h1;
   localparam logic [LSD_SLOPE_W-1:0] LSD_RST_SLOPE               = 3'h0;

   // Timing: calibration reload time and clock dividers.
   localparam int LSD_CLK_MHZ      = 100;
   localparam int LSD_OTP_LOAD_NS  = 2000;
   localparam int LSD_OTP_LOAD_CYC = (LSD_OTP_LOAD_NS * LSD_CLK_MHZ + 999) / 1000;
   localparam int LSD_CLKO_DIV     = 16;
   localparam int LSD_FRAME_DIV    = 48;
   localparam int LSD_CAL_W        = 24;

   // One byte from the serial interface with its register-select flag.
   typedef struct packed {
      logic       register_select_flag;
      logic [7:0] data;
   } lsd_cmd_t;

   // All settings held by the decoder.
   typedef struct packed {
      logic                   clock_pin_drive;
      logic                   clock_source_select;
      logic                   pump_enable;
      logic                   pump_multiplier_select;
      logic                   thermal_comp_enable;
      logic                   thermal_sense_enable;
      logic [LSD_SLOPE_W-1:0] slope_region_a;
      logic [LSD_SLOPE_W-1:0] slope_region_b;
      logic [LSD_SLOPE_W-1:0] slope_region_c;
      logic [LSD_SLOPE_W-1:0] slope_region_d;
   } lsd_cfg_t;

   localparam lsd_cfg_t LSD_CFG_DEFAULT = '{
      clock_pin_drive:        LSD_RST_CLOCK_PIN_DRIVE,
      clock_source_select:    LSD_RST_CLOCK_SOURCE_SELECT,
      pump_enable:            LSD_RST_PUMP_ENABLE,
      pump_multiplier_select: LSD_RST_PUMP_MULT_SELECT,
      thermal_comp_enable:    LSD_RST_THERMAL_COMP_ENABLE,
      thermal_sense_enable:   LSD_RST_THERMAL_SENSE_EN,
      slope_region_a:         LSD_RST_SLOPE,
      slope_region_b:         LSD_RST_SLOPE,
      slope_region_c:         LSD_RST_SLOPE,
      slope_region_d:         LSD_RST_SLOPE
   };

endpackage

// [verif/lsd_host_model.sv]
`timescale 1ns/100ps
// Host side of the command port: strobes one byte per clock, like a serial front end.
module lsd_host_model (
   input  wire logic         clk_in,        // Bench clock.
   output lsd_pkg::lsd_cmd_t cmd_out,       // Byte and register select.
   output logic              cmd_valid_out  // Byte strobe.
);
   // Nothing is offered before the bench asks for it.
   initial begin
      cmd_valid_out = 1'h0;
      cmd_out = '0;
   end
   // Back-to-back calls give one byte per cycle; the strobe stays up between them.
   task automatic send(input logic dflag, input logic [7:0] b);
      @(posedge clk_in);
      #1;
      cmd_valid_out = 1'h1;
      cmd_out = '{register_select_flag: dflag, data: b};
   endtask
   // Idle lines show the inverse byte so that a stale copy can never pass for a command.
   task automatic idle();
      @(posedge clk_in);
      #1;
      cmd_valid_out = 1'h0;
      cmd_out.data = ~cmd_out.data;
   endtask
endmodule

// [verif/lsd_setup_decoder_properties.sv]
`timescale 1ns/100ps
module lsd_setup_decoder_checker (
   input wire logic              clk_in,          // Clock.
   input wire logic              rst_n_in,        // Reset, active low.
   input wire logic              cmd_valid_in,    // Byte strobe.
   input wire lsd_pkg::lsd_cmd_t cmd_in,          // Byte.
   input wire lsd_pkg::lsd_cfg_t cfg_out,         // Settings.
   input wire logic              clk_pin_oe_out,  // Pin enable.
   input wire logic              osc_run_out,     // Oscillator request.
   input wire logic              pump_clk_en_out, // Pump clock.
   input wire logic              otp_busy_out,    // Reload running.
   input wire logic              chip_init_out    // Init pulse.
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // A byte counts only as a command when the select flag is low.
   wire cmd_ok = cmd_valid_in && !cmd_in.register_select_flag;
   wire [7:0] cb = cmd_in.data;
   sequence init_pair_s;
      cmd_ok && cb == 8'h3A ##1 cmd_ok && cb == 8'h04;
   endsequence
   // Oscillator, pump, thermal and slope a and d opcodes update their own fields one cycle later.
   otp_reload_a: assert property (cmd_ok && cb == 8'hD0 |=> otp_busy_out)
      else $error("reload did not start");
   osc_write_a: assert property (cmd_ok && (cb & 8'hFC) == 8'hCC |=>
      {cfg_out.clock_pin_drive, cfg_out.clock_source_select} == $past(cb[1:0]))
      else $error("oscillator fields wrong");
   pump_write_a: assert property (cmd_ok && (cb & 8'hFC) == 8'hC0 |=>
      {cfg_out.pump_enable, cfg_out.pump_multiplier_select} == $past(cb[1:0]))
      else $error("pump fields wrong");
   temp_write_a: assert property (cmd_ok && (cb & 8'hFC) == 8'hC8 |=>
      {cfg_out.thermal_comp_enable, cfg_out.thermal_sense_enable} == $past(cb[1:0]))
      else $error("thermal fields wrong");
   slope_a_write_a: assert property (cmd_ok && (cb & 8'hF8) == 8'h18 |=>
      cfg_out.slope_region_a == $past(cb[2:0])) else $error("slope a wrong");
   slope_d_write_a: assert property (cmd_ok && (cb & 8'hF8) == 8'h30 |=>
      cfg_out.slope_region_d == $past(cb[2:0])) else $error("slope d wrong");
   pin_enable_a: assert property (clk_pin_oe_out ==
      ($past(cfg_out.clock_pin_drive) && !$past(cfg_out.clock_source_select)))
      else $error("clock pin enable wrong");
   pump_clock_a: assert property (pump_clk_en_out == cfg_out.pump_enable &&
      (osc_run_out || !cfg_out.pump_enable)) else $error("pump clock wrong");
   init_reset_a: assert property (init_pair_s |=>
      chip_init_out && otp_busy_out && cfg_out == lsd_pkg::LSD_CFG_DEFAULT)
      else $error("initialize did not reset");
   init_cause_a: assert property (chip_init_out |->
      $past(cmd_ok) && $past(cb) == 8'h04 ##1 !chip_init_out)
      else $error("stray init pulse");
   keep_settings_a: assert property (!cmd_ok |=> $stable(cfg_out))
      else $error("settings changed without command");
endmodule
bind lsd_setup_decoder lsd_setup_decoder_checker chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cfg_out(cfg_out),
   .clk_pin_oe_out(clk_pin_oe_out), .osc_run_out(osc_run_out),
   .pump_clk_en_out(pump_clk_en_out), .otp_busy_out(otp_busy_out),
   .chip_init_out(chip_init_out));

// [verif/tb_lsd_setup_decoder.sv]
`timescale 1ns/100ps
module tb_lsd_setup_decoder;
   localparam lsd_pkg::lsd_cfg_t DEF = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
                                         3'h0, 3'h0, 3'h0, 3'h0};
   logic              clk_in = 1'b0;
   logic              ext_clk_in = 1'b0;
   logic              rst_n_in = 1'b0;
   logic              cmd_valid_in;
   lsd_pkg::lsd_cmd_t cmd_in;
   logic [23:0]       otp_cal_in = 24'h000000;
   logic [4:0]        clko_high_in = 5'h05;
   lsd_pkg::lsd_cfg_t cfg_out, exp_cfg;
   logic [23:0]       cal_out;
   logic              clk_pin_out, clk_pin_oe_out, osc_run_out, pump_clk_en_out;
   logic              otp_busy_out, chip_init_out, disp_clk_out, ext_active_out;
   logic              frame_phase_out, pend;
   logic [31:0]       seed = 32'h33E4;
   int                errors = 0;
   int                checked = 0;
   int                i, k;
   always #5 clk_in = ~clk_in;
   // The external clock never stops once it may be selected.
   always #80 ext_clk_in = ~ext_clk_in;
   lsd_setup_decoder #(.OTP_LOAD_CYCLES(4)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .ext_clk_in(ext_clk_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
      .otp_cal_in(otp_cal_in), .clko_high_in(clko_high_in), .cfg_out(cfg_out),
      .clk_pin_out(clk_pin_out), .clk_pin_oe_out(clk_pin_oe_out), .osc_run_out(osc_run_out),
      .pump_clk_en_out(pump_clk_en_out), .otp_busy_out(otp_busy_out), .cal_out(cal_out),
      .chip_init_out(chip_init_out), .disp_clk_out(disp_clk_out),
      .ext_active_out(ext_active_out), .frame_phase_out(frame_phase_out));
   lsd_host_model host (.clk_in(clk_in), .cmd_out(cmd_in), .cmd_valid_out(cmd_valid_in));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Reference decode of one command byte.
   function automatic lsd_pkg::lsd_cfg_t apply(input lsd_pkg::lsd_cfg_t c,
                                               input logic [7:0] b);
      if ((b & 8'hFC) == 8'hCC) {c.clock_pin_drive, c.clock_source_select} = b[1:0];
      if ((b & 8'hFC) == 8'hC0) {c.pump_enable, c.pump_multiplier_select} = b[1:0];
      if ((b & 8'hFC) == 8'hC8) {c.thermal_comp_enable, c.thermal_sense_enable} = b[1:0];
      if ((b & 8'hF8) == 8'h18) c.slope_region_a = b[2:0];
      if ((b & 8'hF8) == 8'h20) c.slope_region_b = b[2:0];
      if ((b & 8'hF8) == 8'h28) c.slope_region_c = b[2:0];
      if ((b & 8'hF8) == 8'h30) c.slope_region_d = b[2:0];
      return c;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // A stuck wait counts as a mismatch and ends the run.
   task automatic give_up_if(input logic stuck);
      if (stuck) begin
         errors++;
         conclude();
      end
   endtask
   // A new byte other than a repeated first half breaks a pending initialize pair, as the hardware does.
   task automatic expect_byte(input logic dflag, input logic [7:0] b);
      if (!dflag && pend && b == 8'h04) exp_cfg = DEF;
      else if (!dflag) exp_cfg = apply(exp_cfg, b);
      pend = !dflag && b == 8'h3A;
   endtask
   task automatic settle_and_check();
      @(posedge clk_in);
      #1;
      check(32'(cfg_out), 32'(exp_cfg));
      check(32'(clk_pin_oe_out),
            32'(exp_cfg.clock_pin_drive & ~exp_cfg.clock_source_select));
      check(32'(pump_clk_en_out), 32'(exp_cfg.pump_enable));
   endtask
   task automatic issue(input logic dflag, input logic [7:0] b);
      host.send(dflag, b);
      host.idle();
      expect_byte(dflag, b);
      settle_and_check();
   endtask
   // Waits out a calibration reload before anything else happens.
   task automatic reload_done();
      for (k = 0; k < 40 && otp_busy_out !== 1'h0; k++) begin
         @(posedge clk_in);
         #1;
      end
      give_up_if(k == 40);
      check(32'(cal_out), 32'(otp_cal_in));
   endtask
   task automatic do_reset();
      rst_n_in = 1'b0;
      repeat (10) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      exp_cfg = DEF;
      pend = 1'b0;
      settle_and_check();
      check(32'(otp_busy_out), 32'h1);
      reload_done();
   endtask
   initial begin
      seed = lfsr(seed);
      otp_cal_in = seed[23:0];
      do_reset();
      // Every field code of the three control commands, then every slope value.
      for (i = 0; i < 4; i++) begin
         issue(1'b0, 8'hCC | 8'(i));
         issue(1'b0, 8'hC0 | 8'(i));
         issue(1'b0, 8'hC8 | 8'(i));
      end
      for (i = 0; i < 32; i++) issue(1'b0, 8'h18 + 8'(i));
      // New cell contents, so the reload must really fetch them again.
      seed = lfsr(seed);
      otp_cal_in = seed[23:0];
      issue(1'h0, 8'hD0);
      check(32'(otp_busy_out), 32'h1);
      reload_done();
      // Data byte between the halves must cancel the initialize pair.
      issue(1'b0, 8'h3A);
      issue(1'b1, 8'h04);
      issue(1'b0, 8'h04);
      // Repeated first half, back to back, still fires on the second half.
      host.send(1'b0, 8'h3A);
      host.send(1'b0, 8'h3A);
      host.send(1'b0, 8'h04);
      host.idle();
      check(32'(chip_init_out), 32'h1);
      exp_cfg = DEF;
      pend = 1'b0;
      settle_and_check();
      reload_done();
      // Clock pin duty: 16-cycle period, clko_high_in high cycles.
      issue(1'b0, 8'hCE);
      k = 0;
      repeat (32) begin
         @(posedge clk_in);
         #1;
         k += int'(clk_pin_out === 1'b1);
      end
      check(32'(k), 32'(2 * clko_high_in));
      // Hand over to the external clock and back; the pin becomes an input.
      issue(1'b0, 8'hC3);
      issue(1'b0, 8'hCF);
      for (k = 0; k < 200 && ext_active_out !== 1'h1; k++) begin
         @(posedge clk_in);
         #1;
      end
      give_up_if(k == 200);
      check(32'(osc_run_out), 32'h1);
      issue(1'b0, 8'hCC);
      for (k = 0; k < 200 && ext_active_out !== 1'h0; k++) begin
         @(posedge clk_in);
         #1;
      end
      give_up_if(k == 200);
      // Two whole frames on the internal clock: half of each frame is high.
      repeat (4) @(posedge clk_in);
      k = 0;
      repeat (96) begin
         @(posedge clk_in);
         #1;
         k += int'(frame_phase_out === 1'h1);
      end
      check(32'(k), 32'(lsd_pkg::LSD_FRAME_DIV));
      // Random traffic with a few data bytes mixed in.
      repeat (300) begin
         seed = lfsr(seed);
         issue(seed[12:10] == 3'h0, seed[7:0]);
      end
      do_reset();
      conclude();
   end
endmodule
